// >>> core/nfh_host.sv
// Host controller driving the byte-wide flash pins
`timescale 1ns/1ps
module nfh_host (
   input  wire logic             clk,             // 200 MHz clock
   input  wire logic             rst_n,           // Async reset, active low
   input  wire logic             req_valid,       // Cycle request
   input  wire logic [1:0]       req_kind,        // Cycle kind
   input  wire logic [7:0]       req_byte,        // Command, address or data
   input  wire logic             protect_off,     // Raise write protect
   input  wire logic             deselect,        // Release chip enable
   output logic                  req_ready,       // Idle, may take request
   output logic                  rsp_valid,       // Read byte pulse
   output logic [7:0]            rsp_byte,        // Read byte
   output logic                  dev_busy,        // Device busy, registered
   output logic                  cmd_refused,     // Pulse: refusal while busy or reset owed
   output logic                  cmd_latch,       // Command latch pin
   output logic                  addr_latch,      // Address latch pin
   output logic                  chip_en_n,       // Chip enable pin
   output logic                  write_strobe_n,  // Write strobe pin
   output logic                  read_strobe_n,   // Read strobe pin
   output logic                  write_prot_n,    // Write protect pin
   output logic [7:0]            byte_port_o,     // Port output
   output logic                  byte_port_oe,    // Port drive enable
   input  wire logic [7:0]       byte_port_i,     // Port input
   input  wire logic             ready_busy_n     // Ready/busy line, pulled up
);
   //------------------------------------------------------------
   // State
   //------------------------------------------------------------
   typedef enum logic [2:0] {
      NFH_IDLE, NFH_WSETUP, NFH_WHOLD, NFH_RWAIT, NFH_RLOW, NFH_RHIGH, NFH_BWAIT
   } nfh_state_t;

   typedef struct packed {
      nfh_state_t  st;          // Sequencer state
      logic [4:0]  cnt;         // Phase counter
      logic        req_ready;
      logic        rsp_valid;
      logic [7:0]  rsp_byte;
      logic        busy;        // Synchronised ready/busy, 1 = busy
      logic        refused;
      logic        cle, ale, ce_n, we_n, re_n, wp_n;
      logic [7:0]  dout;
      logic        oe;
      logic        last_wr;     // Last strobe was a write
      logic [4:0]  ww_cnt;      // Protect settle counter
      logic        mp_open;     // Second-plane 81 sequence in progress
      logic        need_reset;  // Reset owed after a cached 81/15 ending
   } nfh_s_t;

   nfh_s_t s_ff;                // Registered state
   nfh_s_t nxt_s;               // Next state
   logic   cmd_ok;              // Command allowed now

   // Only status and reset may pass while the device is busy
   always_comb begin
      cmd_ok = (!s_ff.busy && !s_ff.need_reset) ||
               req_byte == nfh_pkg::CMD_STATUS ||
               req_byte == nfh_pkg::CMD_STATUS_MP || req_byte == nfh_pkg::CMD_RESET;
   end

   //------------------------------------------------------------
   // Next state
   //------------------------------------------------------------
   always_comb begin
      nxt_s = s_ff;
      nxt_s.rsp_valid = 1'b0;
      nxt_s.refused = 1'b0;
      nxt_s.busy = !ready_busy_n;
      nxt_s.wp_n = protect_off;
      nxt_s.ww_cnt = !protect_off ? nfh_pkg::WW_CYC :
                     (s_ff.ww_cnt != 5'h0 ? s_ff.ww_cnt - 5'h1 : 5'h0);
      case (s_ff.st)
         NFH_IDLE: begin
            // Strobes high and chip enable held while busy
            nxt_s.we_n = 1'b1;
            nxt_s.re_n = 1'b1;
            nxt_s.oe = 1'b0;
            if (deselect && !s_ff.busy) begin
               nxt_s.ce_n = 1'b1;
            end
            nxt_s.req_ready = 1'b0;
            if (s_ff.req_ready && req_valid) begin
               nxt_s.ce_n = 1'b0;
               nxt_s.cle = 1'b0;
               nxt_s.ale = 1'b0;
               case (nfh_pkg::nfh_kind_t'(req_kind))
                  nfh_pkg::NFH_KIND_CMD: begin
                     if (cmd_ok) begin
                        nxt_s.cle = 1'b1;
                        // Track how a multi-plane cached sequence ends
                        nxt_s.mp_open = req_byte == nfh_pkg::CMD_DATA_IN2;
                        if (s_ff.mp_open && req_byte == nfh_pkg::CMD_PROG_CACHE) begin
                           nxt_s.need_reset = 1'b1;
                        end
                        if (req_byte == nfh_pkg::CMD_RESET) begin
                           nxt_s.need_reset = 1'b0;
                        end
                        nxt_s.dout = req_byte;
                        nxt_s.oe = 1'b1;
                        nxt_s.we_n = 1'b0;
                        nxt_s.cnt = nfh_pkg::SETUP_CYC;
                        nxt_s.st = NFH_WSETUP;
                     end else begin
                        nxt_s.refused = 1'b1;
                        nxt_s.req_ready = 1'b1;
                     end
                  end
                  nfh_pkg::NFH_KIND_ADDR,
                  nfh_pkg::NFH_KIND_WDATA: begin
                     if (s_ff.busy) begin
                        nxt_s.refused = 1'b1;
                        nxt_s.req_ready = 1'b1;
                     end else begin
                        nxt_s.ale = req_kind == 2'(nfh_pkg::NFH_KIND_ADDR);
                        nxt_s.dout = req_byte;
                        nxt_s.oe = 1'b1;
                        nxt_s.we_n = 1'b0;
                        nxt_s.cnt = nfh_pkg::SETUP_CYC;
                        nxt_s.st = NFH_WSETUP;
                     end
                  end
                  default: begin
                     // Serial read: wait write-to-read gap first
                     if (s_ff.busy) begin
                        nxt_s.refused = 1'b1;
                        nxt_s.req_ready = 1'b1;
                     end else begin
                        nxt_s.cnt = s_ff.last_wr ? nfh_pkg::WHR_CYC : 5'h1;
                        nxt_s.st = NFH_RWAIT;
                     end
                  end
               endcase
            end else if (!s_ff.busy || s_ff.req_ready) begin
               nxt_s.req_ready = 1'b1;
            end
         end
         NFH_WSETUP: begin
            // Data input needs protect settled high
            if (s_ff.cnt > 5'h1) begin
               nxt_s.cnt = s_ff.cnt - 5'h1;
            end else if (s_ff.cle || s_ff.ale || s_ff.ww_cnt == 5'h0) begin
               nxt_s.we_n = 1'b1;
               nxt_s.last_wr = 1'b1;
               nxt_s.cnt = nfh_pkg::HOLD_CYC;
               nxt_s.st = NFH_WHOLD;
            end
         end
         NFH_WHOLD: begin
            if (s_ff.cnt > 5'h1) begin
               nxt_s.cnt = s_ff.cnt - 5'h1;
            end else begin
               nxt_s.cle = 1'b0;
               nxt_s.ale = 1'b0;
               nxt_s.oe = 1'b0;
               nxt_s.cnt = nfh_pkg::WB_CYC;
               nxt_s.st = NFH_BWAIT;
            end
         end
         NFH_BWAIT: begin
            // Let a busy after the strobe reach the line
            if (s_ff.cnt > 5'h1) begin
               nxt_s.cnt = s_ff.cnt - 5'h1;
            end else begin
               nxt_s.st = NFH_IDLE;
               nxt_s.req_ready = 1'b1;
            end
         end
         NFH_RWAIT: begin
            if (s_ff.cnt > 5'h1) begin
               nxt_s.cnt = s_ff.cnt - 5'h1;
            end else begin
               nxt_s.re_n = 1'b0;
               nxt_s.cnt = nfh_pkg::REA_CYC;
               nxt_s.st = NFH_RLOW;
            end
         end
         NFH_RLOW: begin
            if (s_ff.cnt > 5'h1) begin
               nxt_s.cnt = s_ff.cnt - 5'h1;
            end else begin
               nxt_s.rsp_byte = byte_port_i;
               nxt_s.rsp_valid = 1'b1;
               nxt_s.re_n = 1'b1;
               nxt_s.last_wr = 1'b0;
               nxt_s.cnt = nfh_pkg::HOLD_CYC;
               nxt_s.st = NFH_RHIGH;
            end
         end
         NFH_RHIGH: begin
            if (s_ff.cnt > 5'h1) begin
               nxt_s.cnt = s_ff.cnt - 5'h1;
            end else begin
               nxt_s.st = NFH_IDLE;
               nxt_s.req_ready = 1'b1;
            end
         end
         default: nxt_s.st = NFH_IDLE;
      endcase
   end

   //------------------------------------------------------------
   // State register
   //------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_ff <= '{st: NFH_IDLE, cnt: 5'h0, req_ready: 1'b0, rsp_valid: 1'b0,
                   rsp_byte: 8'h00, busy: 1'b0, refused: 1'b0, cle: 1'b0, ale: 1'b0,
                   ce_n: 1'b1, we_n: 1'b1, re_n: 1'b1, wp_n: 1'b0, dout: 8'h00,
                   oe: 1'b0, last_wr: 1'b0, ww_cnt: 5'h0, mp_open: 1'b0,
                   need_reset: 1'b0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   // Outputs straight from the register
   assign req_ready      = s_ff.req_ready;
   assign rsp_valid      = s_ff.rsp_valid;
   assign rsp_byte       = s_ff.rsp_byte;
   assign dev_busy       = s_ff.busy;
   assign cmd_refused    = s_ff.refused;
   assign cmd_latch      = s_ff.cle;
   assign addr_latch     = s_ff.ale;
   assign chip_en_n      = s_ff.ce_n;
   assign write_strobe_n = s_ff.we_n;
   assign read_strobe_n  = s_ff.re_n;
   assign write_prot_n   = s_ff.wp_n;
   assign byte_port_o    = s_ff.dout;
   assign byte_port_oe   = s_ff.oe;

   //------------------------------------------------------------
   // Checks
   //------------------------------------------------------------
   property p_latch_excl;
      @(posedge clk) disable iff (!rst_n) !(cmd_latch && addr_latch);
   endproperty
   a_latch_excl: assert property (p_latch_excl) else $error("both latches high");

   property p_cmd_hold;
      @(posedge clk) disable iff (!rst_n)
         $rose(write_strobe_n) && cmd_latch |-> byte_port_oe && $stable(byte_port_o);
   endproperty
   a_cmd_hold: assert property (p_cmd_hold) else $error("command not held");

   property p_addr_hold;
      @(posedge clk) disable iff (!rst_n)
         $rose(write_strobe_n) && addr_latch |-> !cmd_latch && byte_port_oe;
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address not driven");

   property p_busy_strobes;
      @(posedge clk) disable iff (!rst_n)
         dev_busy && $stable(dev_busy) && req_ready |-> write_strobe_n && read_strobe_n;
   endproperty
   a_busy_strobes: assert property (p_busy_strobes) else $error("strobe while busy");

   property p_read_noport;
      @(posedge clk) disable iff (!rst_n) !read_strobe_n |-> !byte_port_oe;
   endproperty
   a_read_noport: assert property (p_read_noport) else $error("port clash on read");

   property p_read_len;
      @(posedge clk) disable iff (!rst_n)
         $fell(read_strobe_n) |-> !read_strobe_n [*5] ##1 read_strobe_n && rsp_valid;
   endproperty
   a_read_len: assert property (p_read_len) else $error("read pulse length");

   property p_data_wp;
      @(posedge clk) disable iff (!rst_n)
         $rose(write_strobe_n) && !cmd_latch && !addr_latch |-> write_prot_n;
   endproperty
   a_data_wp: assert property (p_data_wp) else $error("data with protect low");

   property p_refuse;
      @(posedge clk) disable iff (!rst_n)
         req_ready && req_valid && dev_busy && req_kind == 2'h0 &&
         req_byte != nfh_pkg::CMD_STATUS && req_byte != nfh_pkg::CMD_STATUS_MP &&
         req_byte != nfh_pkg::CMD_RESET |=> cmd_refused && write_strobe_n;
   endproperty
   a_refuse: assert property (p_refuse) else $error("busy command passed");
endmodule

// >>> shared/nfh_pkg.sv
// Constants for the byte-wide flash host controller
//------------------------------------------------------------
// Overview of operation
// - Command byte latched on write strobe rise
// - Address byte latched on write strobe rise
// - Five address bytes: column two, row three
// - Cycle type decoded from latches, strobes
// - Host strobes only status and reset during busy
// - Multi-plane 80/11 then 81/15 or 81/10
// - After 81/15 poll status, then reset
//------------------------------------------------------------
package nfh_pkg;
   // Operation kinds requested by the user
   typedef enum logic [1:0] {
      NFH_KIND_CMD,                        // One command cycle
      NFH_KIND_ADDR,                       // One address cycle
      NFH_KIND_WDATA,                      // One data input cycle
      NFH_KIND_RDATA                       // One serial read cycle
   } nfh_kind_t;

   // Command codes
   localparam logic [7:0] CMD_READ_SETUP  = 8'h00;
   localparam logic [7:0] CMD_READ_START  = 8'h30;
   localparam logic [7:0] CMD_COL_OUT     = 8'h05;
   localparam logic [7:0] CMD_COL_OUT_GO  = 8'he0;
   localparam logic [7:0] CMD_READ_CACHE  = 8'h31;
   localparam logic [7:0] CMD_READ_LAST   = 8'h3f;
   localparam logic [7:0] CMD_DATA_IN     = 8'h80;
   localparam logic [7:0] CMD_PROG        = 8'h10;
   localparam logic [7:0] CMD_COL_IN      = 8'h85;
   localparam logic [7:0] CMD_PROG_CACHE  = 8'h15;
   localparam logic [7:0] CMD_PROG_PLANE  = 8'h11;
   localparam logic [7:0] CMD_DATA_IN2    = 8'h81;
   localparam logic [7:0] CMD_COPY_READ   = 8'h3a;
   localparam logic [7:0] CMD_COPY_PROG   = 8'h8c;
   localparam logic [7:0] CMD_ERASE       = 8'h60;
   localparam logic [7:0] CMD_ERASE_GO    = 8'hd0;
   localparam logic [7:0] CMD_ID_READ     = 8'h90;
   localparam logic [7:0] CMD_STATUS      = 8'h70;
   localparam logic [7:0] CMD_STATUS_MP   = 8'h71;
   localparam logic [7:0] CMD_RESET       = 8'hff;

   // Array geometry
   localparam int PAGE_BYTES      = 4352;
   localparam int PAGE_MAIN_BYTES = 4096;
   localparam int PAGE_SPARE      = 256;
   localparam int PAGES_PER_BLOCK = 64;
   localparam int BLOCKS          = 2048;
   localparam int COL_W           = 13;   // Column bits
   localparam int ROW_W           = 17;   // Row bits
   localparam int PAGE_SEL_W      = 6;    // Row bits for page in block

   // Strobe timing in ns (min times, rounded up)
   localparam int CLK_NS      = 5;
   localparam int T_SETUP_NS  = 12;       // Latch/data setup and pulse width
   localparam int T_HOLD_NS   = 10;       // Strobe high hold
   localparam int T_REA_NS    = 20;       // Read access
   localparam int T_WHR_NS    = 60;       // Write high to read low
   localparam int T_WB_NS     = 100;      // Write high to busy
   localparam int T_WW_NS     = 100;      // Protect high to write low
   localparam logic [4:0] SETUP_CYC = 5'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [4:0] HOLD_CYC  = 5'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [4:0] REA_CYC   = 5'((T_REA_NS + CLK_NS - 1) / CLK_NS + 1);
   localparam logic [4:0] WHR_CYC   = 5'((T_WHR_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [4:0] WB_CYC    = 5'((T_WB_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [4:0] WW_CYC    = 5'((T_WW_NS + CLK_NS - 1) / CLK_NS);
endpackage

// >>> verification/nfh_dev_model.sv
// Behavioural flash device on the far side of the host controller
`timescale 1ns/1ps
module nfh_dev_model #(
   parameter int         BUSY_NS  = 600,   // Shortened array busy time
   parameter logic [7:0] MAKER_ID = 8'h5c, // Arbitrary maker code
   parameter logic [7:0] DEV_ID   = 8'ha3  // Arbitrary device code
) (
   input  wire logic       cmd_latch,      // Command latch
   input  wire logic       addr_latch,     // Address latch
   input  wire logic       chip_en_n,      // Chip enable
   input  wire logic       write_strobe_n, // Write strobe
   input  wire logic       read_strobe_n,  // Read strobe
   input  wire logic       write_prot_n,   // Write protect
   input  wire logic [7:0] byte_port,      // Resolved port
   output logic [7:0]      dq,             // Device port value
   output logic            busy_pull       // Open drain pulls low
);
   logic [7:0]  page [0:63]; // Cache, low column bits
   logic [7:0]  last_cmd;    // Last accepted command
   logic [7:0]  mode;        // Output source
   logic [12:0] col;         // Column counter
   logic [16:0] row;         // Row address
   logic [2:0]  acnt;        // Address byte count
   logic [7:0]  out_b;       // Output byte
   logic [7:0]  b;           // Captured byte
   logic        idn;         // Id byte index
   logic        dq_oe;       // Device drives port
   logic        standby;     // Low power state
   initial begin
      busy_pull = 1'b0;
      last_cmd = 8'h00;
      mode = 8'h00;
      {col, row, acnt, out_b, idn} = '0;
   end
   // Drive only while read strobe low; released port shows inverse
   assign dq_oe = !chip_en_n && !read_strobe_n && write_strobe_n && !cmd_latch && !addr_latch;
   assign dq = dq_oe ? out_b : ~out_b;
   assign standby = chip_en_n && !busy_pull;
   // Busy period, starts after strobe rise
   task automatic busy(input int ns);
      #20 busy_pull = 1'b1;
      #(ns) busy_pull = 1'b0;
   endtask
   // Bus cycle capture on write strobe rise
   always @(posedge write_strobe_n) begin
      b = byte_port;
      if (chip_en_n) begin
      end else if (cmd_latch && (!busy_pull || b == 8'h70 || b == 8'h71 || b == 8'hff)) begin
         last_cmd = b;
         acnt = (b == 8'h60) ? 3'd2 : 3'd0;
         case (b)
            8'h70, 8'h71: mode = 8'h70;
            8'h90: begin
               mode = 8'h90;
               idn = 1'b0;
            end
            8'hff: begin
               mode = 8'h00;
               fork busy(50); join_none
            end
            8'h30, 8'h31, 8'h3f, 8'h3a: begin
               mode = 8'h00;
               for (int i = 0; i < 64; i++) page[i] = row[7:0] + 8'(i);
               fork busy(BUSY_NS); join_none
            end
            8'h10, 8'h11, 8'h15, 8'hd0: if (write_prot_n) fork busy(BUSY_NS); join_none
            default: mode = 8'h00;
         endcase
      end else if (addr_latch) begin
         case (acnt)
            3'd0: col[7:0] = b;
            3'd1: col[12:8] = b[4:0];
            3'd2: row[7:0] = b;
            3'd3: row[15:8] = b;
            default: row[16] = b[0];
         endcase
         acnt++;
      end else if (!cmd_latch && write_prot_n) begin
         page[col[5:0]] = b;
         col++;
      end
   end
   // Serial output on read strobe fall
   always @(negedge read_strobe_n) if (!chip_en_n) begin
      if (mode == 8'h70) out_b = {1'b0, !busy_pull, 6'h00};
      else if (mode == 8'h90) begin
         out_b = idn ? DEV_ID : MAKER_ID;
         idn = 1'b1;
      end else begin
         out_b = page[col[5:0]];
         col++;
      end
   end
endmodule

// >>> verification/nfh_host_tb.sv
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module nfh_host_tb;
   logic clk, rst_n, req_valid, protect_off, deselect;
   logic [1:0] req_kind;
   logic [7:0] req_byte, rsp_byte, byte_port_o, dq, port, b;
   logic req_ready, rsp_valid, dev_busy, cmd_refused, cmd_latch, addr_latch;
   logic chip_en_n, write_strobe_n, read_strobe_n, write_prot_n, byte_port_oe, busy_pull;
   int errors, num_checks, cyc;
   assign port = byte_port_oe ? byte_port_o : dq; // Resolved port
   nfh_host dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_kind(req_kind),
      .req_byte(req_byte), .protect_off(protect_off), .deselect(deselect),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .dev_busy(dev_busy),
      .cmd_refused(cmd_refused), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
      .chip_en_n(chip_en_n), .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
      .write_prot_n(write_prot_n), .byte_port_o(byte_port_o), .byte_port_oe(byte_port_oe),
      .byte_port_i(port), .ready_busy_n(!busy_pull));
   nfh_dev_model dev (.cmd_latch(cmd_latch), .addr_latch(addr_latch), .chip_en_n(chip_en_n),
      .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
      .write_prot_n(write_prot_n), .byte_port(port), .dq(dq), .busy_pull(busy_pull));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         print_verdict();
      end
   end
   task automatic print_verdict;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // One request, taken when ready
   task automatic op(input logic [1:0] k, input logic [7:0] v);
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 400) begin @(negedge clk); n++; end
      req_kind = k;
      req_byte = v;
      req_valid = 1'b1;
      @(negedge clk);
      req_valid = 1'b0;
   endtask
   task automatic rd(output logic [7:0] v);
      int n;
      n = 0;
      op(2'd3, 8'h00);
      while (rsp_valid !== 1'b1 && n < 60) begin @(negedge clk); n++; end
      v = rsp_byte;
   endtask
   task automatic ad(input logic [12:0] c, input logic [16:0] r);
      op(2'd1, c[7:0]);
      op(2'd1, {3'h0, c[12:8]});
      op(2'd1, r[7:0]);
      op(2'd1, r[15:8]);
      op(2'd1, {7'h00, r[16]});
   endtask
   // Wait for busy level v, bounded
   task automatic wbusy(input logic v);
      int n;
      n = 0;
      while (dev_busy !== v && n < 400) begin @(negedge clk); n++; end
   endtask
   // Page read, refusal and status during busy
   task automatic s_read;
      op(2'd0, 8'h00);
      ad(13'h0005, 17'h10203);
      op(2'd0, 8'h30);
      `CHK("row", 17'h10203, dev.row)
      wbusy(1'b1);
      `CHK("busy", 1'b1, dev_busy)
      op(2'd0, 8'h80);
      `CHK("refused", 1'b1, cmd_refused)
      repeat (3) @(negedge clk);
      op(2'd0, 8'h70);
      repeat (8) @(negedge clk);
      `CHK("status acc", 8'h70, dev.last_cmd)
      wbusy(1'b0);
      rd(b);
      `CHK("status", 8'h40, b)
      op(2'd0, 8'h00);
      for (int i = 0; i < 3; i++) begin
         rd(b);
         `CHK("rdata", 8'h08 + 8'(i), b)
      end
   endtask
   task automatic s_prog;
      op(2'd0, 8'h80);
      ad(13'h0002, 17'h00040);
      op(2'd2, 8'ha1);
      op(2'd2, 8'hb2);
      op(2'd0, 8'h10);
      wbusy(1'b1);
      `CHK("prog busy", 1'b1, dev_busy)
      `CHK("data0", 8'ha1, dev.page[2])
      `CHK("data1", 8'hb2, dev.page[3])
      wbusy(1'b0);
   endtask
   task automatic s_prot;
      protect_off = 1'b0;
      op(2'd0, 8'h60);
      repeat (3) op(2'd1, 8'h00);
      op(2'd0, 8'hd0);
      repeat (60) @(negedge clk);
      `CHK("inhibit", 1'b0, dev_busy)
      protect_off = 1'b1;
   endtask
   task automatic s_id;
      op(2'd0, 8'h90);
      op(2'd1, 8'h00);
      rd(b);
      `CHK("maker", dev.MAKER_ID, b)
      rd(b);
      `CHK("device", dev.DEV_ID, b)
   endtask
   task automatic s_stby;
      deselect = 1'b1;
      repeat (40) @(negedge clk);
      `CHK("standby", 1'b1, dev.standby)
      `CHK("ce high", 1'b1, chip_en_n)
      deselect = 1'b0;
      op(2'd0, 8'h30);
      wbusy(1'b1);
      deselect = 1'b1;
      repeat (10) @(negedge clk);
      `CHK("no standby", 1'b0, dev.standby)
      `CHK("ce held", 1'b0, chip_en_n)
      deselect = 1'b0;
      wbusy(1'b0);
   endtask
   // Every command code reaches the device
   task automatic s_codes;
      logic [7:0] c [20] = '{8'h00, 8'h30, 8'h05, 8'he0, 8'h31, 8'h3f, 8'h80, 8'h10, 8'h85,
         8'h15, 8'h11, 8'h81, 8'h3a, 8'h8c, 8'h60, 8'hd0, 8'h90, 8'h70, 8'h71, 8'hff};
      foreach (c[i]) begin
         op(2'd0, c[i]);
         repeat (30) @(negedge clk);
         `CHK("code", c[i], dev.last_cmd)
         wbusy(1'b0);
      end
   endtask
   // Cached second-plane program ended by 81/15: poll, then reset
   task automatic s_mp;
      op(2'd0, 8'h81);
      ad(13'h0000, 17'h00080);
      op(2'd2, 8'h5a);
      op(2'd0, 8'h15);
      wbusy(1'b1);
      wbusy(1'b0);
      op(2'd0, 8'h80);
      `CHK("owed reset", 1'b1, cmd_refused)
      repeat (3) @(negedge clk);
      op(2'd0, 8'h70);
      rd(b);
      `CHK("poll", 8'h40, b)
      op(2'd0, 8'hff);
      repeat (30) @(negedge clk);
      wbusy(1'b0);
      op(2'd0, 8'h80);
      `CHK("after reset", 1'b0, cmd_refused)
      repeat (10) @(negedge clk);
      `CHK("next op", 8'h80, dev.last_cmd)
   endtask
   initial begin
      {errors, num_checks, cyc} = '0;
      rst_n = 1'b0;
      {req_valid, deselect, req_kind, req_byte} = '0;
      protect_off = 1'b1;
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      s_read();
      s_prog();
      s_prot();
      s_id();
      s_stby();
      s_codes();
      s_mp();
      print_verdict();
   end
endmodule
